// file: design/pdr_remote_io.sv
// remote connector logic of the pump drive: input conditioning, command arbitration,
// status outputs, relays, analog speed paths and the half-duplex 8N1 serial link
// assumes inputs synchronous to core_clk; speed values arrive as permille and millivolts
`timescale 1ns/1ns
module pdr_remote_io import pdr_pkg::*; #(
	parameter int unsigned DEB_CYC = DEBOUNCE_CYC,
	parameter int unsigned ACK_CYC = ACK_MIN_CYC,
	parameter int unsigned BAUD_CYC = BAUD_DIV_CYC
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire pdr_remote_in_type remote_in,
	input wire logic [15:0] speed_setpoint_input,
	input wire logic self_test_ok,
	input wire logic [9:0] rotor_speed,
	input wire logic error_present,
	input wire logic warning_present,
	output pdr_drive_cmd_type drive_cmd,
	output logic [9:0] speed_target,
	output logic error_ack,
	output logic speed_reached_output,
	output logic fault_free_output,
	output logic remote_prio_output,
	output logic [9:0] speed_analog_output,
	output pdr_relay_type relays,
	input wire logic rs485_rx,
	output logic rs485_tx,
	output logic rs485_tx_oe
);
	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} pdr_rx_state_type;

	// true when any configurable input carrying function fn is high
	function automatic logic fn_route(input logic [2:0] din, input logic [5:0] map, input pdr_in_fn_type fn);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 3; i++) begin
			if (din[i] && map[2*i +: 2] == fn) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction : fn_route

	// picks the status bit a configurable output shows
	function automatic logic fn_src(input logic [1:0] sel, input logic [3:0] st);
		return st[sel];
	endfunction : fn_src

	// merges write data into a register under byte enables
	function automatic logic [31:0] fn_be(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return res;
	endfunction : fn_be

	logic [7:0] sync1_ff, sync2_ff, deb_ff;
	logic [31:0] deb_cnt_ff [8];
	logic [31:0] ack_cnt_ff;
	logic ack_done_ff, station_q_ff;
	logic [5:0] cmd_ff;
	logic [12:0] map_ff;
	logic [9:0] standby_ff, switch_ff, addr_ff;
	logic wait_ff;
	logic [31:0] rdata_ff;
	pdr_drive_cmd_type drive_ff;
	logic [9:0] target_ff, analog_ff;
	logic ack_pulse_ff, reached_ff, fault_free_ff, prio_ff;
	pdr_relay_type relay_ff;
	logic [9:0] tx_sh_ff;
	logic [3:0] tx_bits_ff;
	logic [31:0] tx_cnt_ff;
	logic tx_ff, tx_oe_ff;
	pdr_rx_state_type rx_state_ff;
	logic rx_s1_ff, rx_s2_ff;
	logic [31:0] rx_cnt_ff, gap_cnt_ff;
	logic [2:0] rx_bit_ff;
	logic [7:0] rx_sh_ff, rx_data_ff;
	logic rx_valid_ff, frame_ok_ff;
	logic [1:0] hdr_idx_ff;
	logic [13:0] addr_acc_ff;

	pdr_remote_in_type rin;
	logic [5:0] eff;
	logic do1_sel, do2_sel, st_speed, st_nofault;
	logic [15:0] set_div;
	logic [9:0] set_permille;
	logic [3:0] stat4;
	logic req_blocked, acc_go, wr_go, rd_go;
	logic byte_done;
	logic [3:0] digit;
	logic [13:0] nxt_addr_acc;

	// 2-flop synchronisers; only the second stage feeds the debouncers
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sync1_ff <= 8'h00;
			sync2_ff <= 8'h00;
		end else begin
			sync1_ff <= remote_in;
			sync2_ff <= sync1_ff;
		end
	end

	// each input must hold a new level for DEB_CYC cycles before it is taken
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			deb_ff <= 8'h00;
			for (int i = 0; i < 8; i++) begin
				deb_cnt_ff[i] <= 32'h0;
			end
		end else begin
			for (int i = 0; i < 8; i++) begin
				if (sync2_ff[i] == deb_ff[i]) begin
					deb_cnt_ff[i] <= 32'h0;
				end else if (deb_cnt_ff[i] >= DEB_CYC - 1) begin
					deb_ff[i] <= sync2_ff[i];
					deb_cnt_ff[i] <= 32'h0;
				end else begin
					deb_cnt_ff[i] <= deb_cnt_ff[i] + 32'h1;
				end
			end
		end
	end

	assign rin = pdr_remote_in_type'(deb_ff);

	// remote priority picks the connector, otherwise software commands steer the drive
	always_comb begin
		if (rin.remote_prio) begin
			eff[0] = rin.motor;
			eff[1] = rin.station;
			eff[2] = fn_route({rin.sealing_gas_input, rin.heating_input, rin.venting_enable_input},
				map_ff[5:0], FN_VENT);
			eff[3] = rin.standby;
			eff[4] = fn_route({rin.sealing_gas_input, rin.heating_input, rin.venting_enable_input},
				map_ff[5:0], FN_HEAT);
			eff[5] = fn_route({rin.sealing_gas_input, rin.heating_input, rin.venting_enable_input},
				map_ff[5:0], FN_SEAL);
		end else begin
			eff = cmd_ff;
		end
	end

	// the acknowledge input counts its high time; a short pulse never fires
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ack_cnt_ff <= 32'h0;
			ack_done_ff <= 1'b0;
			station_q_ff <= 1'b0;
			ack_pulse_ff <= 1'b0;
		end else begin
			station_q_ff <= eff[1];
			ack_pulse_ff <= 1'b0;
			if (!(rin.err_ack && rin.remote_prio)) begin
				ack_cnt_ff <= 32'h0;
				ack_done_ff <= 1'b0;
			end else if (!ack_done_ff && ack_cnt_ff >= ACK_CYC - 1) begin
				ack_done_ff <= 1'b1;
				ack_pulse_ff <= 1'b1;
			end else if (!ack_done_ff) begin
				ack_cnt_ff <= ack_cnt_ff + 32'h1;
			end
			if (eff[1] && !station_q_ff) begin
				ack_pulse_ff <= 1'b1;
			end
		end
	end

	// analog setpoint: one permille per 10 mV, nominal below 2 V
	assign set_div = speed_setpoint_input / MV_PER_PERMILLE;
	always_comb begin
		if (speed_setpoint_input < SET_MIN_MV || set_div > {6'h00, SPEED_FULL}) begin
			set_permille = SPEED_FULL;
		end else begin
			set_permille = set_div[9:0];
		end
	end

	assign st_speed = rotor_speed >= switch_ff;
	assign st_nofault = !error_present;
	assign stat4 = {prio_ff, warning_present, st_nofault, st_speed};
	assign do1_sel = fn_src(map_ff[MAP_DO1_LSB +: 2], stat4);
	assign do2_sel = fn_src(map_ff[MAP_DO2_LSB +: 2], stat4);

	// drive commands and speed target, all registered
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			drive_ff <= '0;
			target_ff <= SPEED_FULL;
		end else begin
			drive_ff.motor_on <= eff[1] && eff[0] && self_test_ok;
			drive_ff.station_on <= eff[1];
			drive_ff.vent_permit <= eff[2];
			drive_ff.standby_on <= eff[3];
			drive_ff.heating_on <= eff[4];
			drive_ff.seal_gas_open <= eff[5];
			target_ff <= eff[3] ? standby_ff : set_permille;
		end
	end

	// status pins and relays; fault-free resets high so it stands from power-up
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			reached_ff <= 1'b0;
			fault_free_ff <= 1'b1;
			prio_ff <= 1'b0;
			analog_ff <= 10'd0;
			relay_ff <= '0;
		end else begin
			reached_ff <= do1_sel;
			fault_free_ff <= do2_sel;
			prio_ff <= rin.remote_prio;
			analog_ff <= (rotor_speed > SPEED_FULL) ? SPEED_FULL : rotor_speed;
			relay_ff.relay1 <= st_speed ^ map_ff[MAP_INV_LSB];
			relay_ff.relay2 <= st_nofault ^ map_ff[MAP_INV_LSB + 1];
			relay_ff.relay3 <= warning_present ^ map_ff[MAP_INV_LSB + 2];
		end
	end

	// bus slave: one wait state per access; a tx write waits while a byte is still going out
	assign req_blocked = avs_write && avs_address == REG_TXDATA && tx_bits_ff != 4'd0;
	assign acc_go = (avs_read || avs_write) && wait_ff && !req_blocked;
	assign wr_go = avs_write && !wait_ff;
	assign rd_go = avs_read && !wait_ff;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wait_ff <= 1'b1;
			rdata_ff <= 32'h0;
		end else begin
			wait_ff <= !acc_go;
			if (acc_go && avs_read) begin
				case (avs_address)
					REG_CMD: rdata_ff <= {26'h0, cmd_ff};
					REG_MAP: rdata_ff <= {19'h0, map_ff};
					REG_SPEED: rdata_ff <= {6'h0, switch_ff, 6'h0, standby_ff};
					REG_ADDR: rdata_ff <= {22'h0, addr_ff};
					REG_STATUS: rdata_ff <= {12'h0, frame_ok_ff, tx_bits_ff != 4'd0, error_present,
						warning_present, st_speed, prio_ff, deb_ff, drive_ff};
					REG_TXDATA: rdata_ff <= {31'h0, tx_bits_ff != 4'd0};
					REG_RXDATA: rdata_ff <= {23'h0, rx_valid_ff, rx_data_ff};
					default: rdata_ff <= 32'h0;
				endcase
			end
		end
	end

	// software registers: commands, function map, speeds, address
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cmd_ff <= CMD_RST;
			map_ff <= MAP_RST;
			standby_ff <= STANDBY_RST;
			switch_ff <= SWITCH_RST;
			addr_ff <= ADDR_RST;
		end else if (wr_go) begin
			case (avs_address)
				REG_CMD: cmd_ff <= 6'(fn_be({26'h0, cmd_ff}, avs_writedata, avs_byteenable));
				REG_MAP: map_ff <= 13'(fn_be({19'h0, map_ff}, avs_writedata, avs_byteenable));
				REG_SPEED: begin
					standby_ff <= 10'(fn_be({22'h0, standby_ff}, avs_writedata, avs_byteenable));
					switch_ff <= 10'(fn_be({6'h0, switch_ff, 16'h0}, avs_writedata, avs_byteenable) >> 16);
				end
				REG_ADDR: addr_ff <= 10'(fn_be({22'h0, addr_ff}, avs_writedata, avs_byteenable));
				default: ;
			endcase
		end
	end

	// transmitter: start bit, 8 data lsb first, stop bit; drives the line only while sending
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tx_sh_ff <= 10'h3ff;
			tx_bits_ff <= 4'd0;
			tx_cnt_ff <= 32'h0;
			tx_ff <= 1'b1;
			tx_oe_ff <= 1'b0;
		end else if (wr_go && avs_address == REG_TXDATA && avs_byteenable[0]) begin
			tx_sh_ff <= {1'b1, avs_writedata[7:0], 1'b0};
			tx_bits_ff <= 4'd10;
			tx_cnt_ff <= 32'h0;
		end else if (tx_bits_ff != 4'd0) begin
			tx_oe_ff <= 1'b1;
			tx_ff <= tx_sh_ff[0];
			if (tx_cnt_ff >= BAUD_CYC - 1) begin
				tx_cnt_ff <= 32'h0;
				tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
				tx_bits_ff <= tx_bits_ff - 4'd1;
			end else begin
				tx_cnt_ff <= tx_cnt_ff + 32'h1;
			end
		end else begin
			tx_ff <= 1'b1;
			tx_oe_ff <= 1'b0;
		end
	end

	// receiver line synchroniser
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rx_s1_ff <= 1'b1;
			rx_s2_ff <= 1'b1;
		end else begin
			rx_s1_ff <= rs485_rx;
			rx_s2_ff <= rx_s1_ff;
		end
	end

	// receiver: samples each bit at its middle; a bad stop bit drops the byte
	assign byte_done = rx_state_ff == RX_STOP && rx_cnt_ff >= BAUD_CYC - 1 && rx_s2_ff;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rx_state_ff <= RX_IDLE;
			rx_cnt_ff <= 32'h0;
			rx_bit_ff <= 3'd0;
			rx_sh_ff <= 8'h00;
		end else begin
			case (rx_state_ff)
				RX_IDLE: begin
					rx_cnt_ff <= 32'h0;
					if (!rx_s2_ff) begin
						rx_state_ff <= RX_START;
					end
				end
				RX_START: begin
					if (rx_cnt_ff >= BAUD_CYC / 2 - 1) begin
						rx_cnt_ff <= 32'h0;
						rx_bit_ff <= 3'd0;
						rx_state_ff <= rx_s2_ff ? RX_IDLE : RX_DATA;
					end else begin
						rx_cnt_ff <= rx_cnt_ff + 32'h1;
					end
				end
				RX_DATA: begin
					if (rx_cnt_ff >= BAUD_CYC - 1) begin
						rx_cnt_ff <= 32'h0;
						rx_sh_ff <= {rx_s2_ff, rx_sh_ff[7:1]};
						rx_bit_ff <= rx_bit_ff + 3'd1;
						if (rx_bit_ff == 3'd7) begin
							rx_state_ff <= RX_STOP;
						end
					end else begin
						rx_cnt_ff <= rx_cnt_ff + 32'h1;
					end
				end
				RX_STOP: begin
					if (rx_cnt_ff >= BAUD_CYC - 1) begin
						rx_state_ff <= RX_IDLE;
					end else begin
						rx_cnt_ff <= rx_cnt_ff + 32'h1;
					end
				end
				default: rx_state_ff <= RX_IDLE;
			endcase
		end
	end

	// frame filter: after an idle gap the first three bytes are decimal address digits
	assign digit = rx_sh_ff[3:0];
	assign nxt_addr_acc = 14'(addr_acc_ff * 14'd10 + {10'h0, digit});
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			gap_cnt_ff <= 32'h0;
			hdr_idx_ff <= 2'd0;
			addr_acc_ff <= 14'h0;
			frame_ok_ff <= 1'b0;
			rx_data_ff <= 8'h00;
			rx_valid_ff <= 1'b0;
		end else begin
			if (rx_state_ff != RX_IDLE || !rx_s2_ff) begin
				gap_cnt_ff <= 32'h0;
			end else if (gap_cnt_ff >= GAP_BITS * BAUD_CYC) begin
				hdr_idx_ff <= 2'd0;
				addr_acc_ff <= 14'h0;
				frame_ok_ff <= 1'b0;
			end else begin
				gap_cnt_ff <= gap_cnt_ff + 32'h1;
			end
			if (rd_go && avs_address == REG_RXDATA) begin
				rx_valid_ff <= 1'b0;
			end
			if (byte_done && hdr_idx_ff != 2'd3) begin
				hdr_idx_ff <= hdr_idx_ff + 2'd1;
				addr_acc_ff <= nxt_addr_acc;
				if (hdr_idx_ff == 2'd2) begin
					frame_ok_ff <= nxt_addr_acc == {4'h0, addr_ff} ||
						nxt_addr_acc == {4'h0, GROUP_ADDR};
				end
			end else if (byte_done && frame_ok_ff) begin
				rx_data_ff <= rx_sh_ff;
				rx_valid_ff <= 1'b1; // set wins over the read clear
			end
		end
	end

	assign avs_readdata = rdata_ff;
	assign avs_waitrequest = wait_ff;
	assign drive_cmd = drive_ff;
	assign speed_target = target_ff;
	assign error_ack = ack_pulse_ff;
	assign speed_reached_output = reached_ff;
	assign fault_free_output = fault_free_ff;
	assign remote_prio_output = prio_ff;
	assign speed_analog_output = analog_ff;
	assign relays = relay_ff;
	assign rs485_tx = tx_ff;
	assign rs485_tx_oe = tx_oe_ff;
endmodule : pdr_remote_io

// file: design/pdr_pkg.sv
// package for the pump drive remote-control block: map, reset values, timing, carriers
// assumes one 100 MHz clock and an avalon-mm master for software access
// Summary of operation
// - venting permitted only while venting enable high
// - motor runs on station, motor, self-test ok
// - motor input toggles motor, never triggers venting
// - station on starts station, acknowledges errors
// - standby input selects standby speed, default 66.7%
// - heating follows heating input
// - sealing-gas valve follows sealing-gas input
// - acknowledge needs high pulse of 500 ms
// - remote priority input makes remote inputs win
// - 2-10 V maps to 20-100%, else nominal
// - speed-reached high at switchpoint, default 80%
// - fault-free output high unless error present
// - priority status output shows remote priority
// - analog output follows rotor speed, full scale
// - relay one active at speed switchpoint
// - relay two active while no malfunction
// - relay three active while warning present
// - serial link 9600 baud, 8N1
// - accept group address 963 and own address
// - input and output functions reconfigurable by software
package pdr_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned BAUD_RATE = 9600;
	localparam int unsigned BAUD_DIV_CYC = CLK_HZ / BAUD_RATE;
	localparam int unsigned DEBOUNCE_MS = 10;
	localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
	localparam int unsigned ACK_MIN_MS = 500;
	localparam int unsigned ACK_MIN_CYC = ACK_MIN_MS * (CLK_HZ / 1000);
	localparam int unsigned GAP_BITS = 20;
	// register byte offsets
	localparam logic [4:0] REG_CMD = 5'h00;
	localparam logic [4:0] REG_MAP = 5'h04;
	localparam logic [4:0] REG_SPEED = 5'h08;
	localparam logic [4:0] REG_ADDR = 5'h0c;
	localparam logic [4:0] REG_STATUS = 5'h10;
	localparam logic [4:0] REG_TXDATA = 5'h14;
	localparam logic [4:0] REG_RXDATA = 5'h18;
	// reset values and speed figures, speeds in permille of nominal
	localparam logic [5:0] CMD_RST = 6'h00;
	localparam logic [12:0] MAP_RST = 13'h0124;
	localparam logic [9:0] STANDBY_RST = 10'd667;
	localparam logic [9:0] SWITCH_RST = 10'd800;
	localparam logic [9:0] ADDR_RST = 10'd1;
	localparam logic [9:0] GROUP_ADDR = 10'd963;
	localparam logic [9:0] SPEED_FULL = 10'd1000;
	localparam logic [15:0] SET_MIN_MV = 16'd2000;
	localparam logic [15:0] MV_PER_PERMILLE = 16'd10;
	// map and speed register field positions
	localparam int unsigned MAP_DO1_LSB = 6;
	localparam int unsigned MAP_DO2_LSB = 8;
	localparam int unsigned MAP_INV_LSB = 10;
	localparam int unsigned SPEED_SW_LSB = 16;
	// functions a configurable input can carry
	typedef enum logic [1:0] {FN_VENT, FN_HEAT, FN_SEAL, FN_NONE} pdr_in_fn_type;
	// sources a configurable output can show
	typedef enum logic [1:0] {SRC_SPEED, SRC_NOFAULT, SRC_WARN, SRC_PRIO} pdr_out_src_type;
	typedef struct packed {
		logic remote_prio;
		logic err_ack;
		logic sealing_gas_input;
		logic heating_input;
		logic standby;
		logic station;
		logic motor;
		logic venting_enable_input;
	} pdr_remote_in_type;
	typedef struct packed {
		logic seal_gas_open;
		logic heating_on;
		logic standby_on;
		logic vent_permit;
		logic station_on;
		logic motor_on;
	} pdr_drive_cmd_type;
	typedef struct packed {
		logic relay3;
		logic relay2;
		logic relay1;
	} pdr_relay_type;
endpackage : pdr_pkg

// file: testbench/pdr_remote_io_props.sv
// concurrent checks on the ports of the pump drive remote-control block
// assumes short sim parameters (debounce 4, baud 16) and default map, switchpoint and relay polarity
`timescale 1ns/1ns
module pdr_remote_io_props import pdr_pkg::*; (
	input wire logic core_clk,
	input wire logic rstn,
	input wire pdr_remote_in_type remote_in,
	input wire logic [9:0] rotor_speed,
	input wire logic error_present,
	input wire logic warning_present,
	input wire pdr_drive_cmd_type drive_cmd,
	input wire logic error_ack,
	input wire logic speed_reached_output,
	input wire logic fault_free_output,
	input wire logic remote_prio_output,
	input wire logic [9:0] speed_analog_output,
	input wire pdr_relay_type relays,
	input wire logic rs485_tx,
	input wire logic rs485_tx_oe
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// run of equal priority samples; eight cover sync, debounce and output flops
	logic [3:0] prio_run;
	logic prio_last;
	always_ff @(posedge core_clk) begin
		prio_last <= remote_in.remote_prio;
		prio_run <= (!rstn || remote_in.remote_prio != prio_last) ? 4'h0 : prio_run + 4'h1;
	end
	sequence s_prio_low_held; prio_run >= 4'd7 && !prio_last; endsequence
	sequence s_prio_high_held; prio_run >= 4'd7 && prio_last; endsequence
	property p_prio_off; s_prio_low_held |-> !remote_prio_output; endproperty
	property p_prio_on; s_prio_high_held |-> remote_prio_output; endproperty
	property p_prio_deb; $rose(remote_in.remote_prio) |=> $stable(remote_prio_output) [*2]; endproperty
	property p_motor; drive_cmd.motor_on |-> drive_cmd.station_on; endproperty
	property p_no_vent; $fell(drive_cmd.motor_on) && drive_cmd.station_on |-> $stable(drive_cmd.vent_permit); endproperty
	property p_speed; 1'b1 |=> speed_reached_output == ($past(rotor_speed) >= SWITCH_RST); endproperty
	property p_relay1; relays.relay1 == speed_reached_output; endproperty
	property p_fault; error_present |=> !fault_free_output; endproperty
	property p_relay2; 1'b1 |=> relays.relay2 == !$past(error_present); endproperty
	property p_relay3; $rose(warning_present) |=> relays.relay3; endproperty
	property p_analog; rotor_speed <= SPEED_FULL |=> speed_analog_output == $past(rotor_speed); endproperty
	property p_ack; error_ack |=> !error_ack; endproperty
	property p_start; $rose(rs485_tx_oe) |-> (!rs485_tx) [*8]; endproperty
	a_prio_off: assert property (p_prio_off) else $error("priority status stays high");
	a_prio_on: assert property (p_prio_on) else $error("priority status stays low");
	a_prio_deb: assert property (p_prio_deb) else $error("priority input undebounced");
	a_motor: assert property (p_motor) else $error("motor runs without station");
	a_no_vent: assert property (p_no_vent) else $error("motor stop touched venting");
	a_speed: assert property (p_speed) else $error("speed reached output wrong");
	a_relay1: assert property (p_relay1) else $error("relay one disagrees with speed");
	a_fault: assert property (p_fault) else $error("fault free output high on error");
	a_relay2: assert property (p_relay2) else $error("relay two wrong");
	a_relay3: assert property (p_relay3) else $error("relay three not raised");
	a_analog: assert property (p_analog) else $error("analog output wrong");
	a_ack: assert property (p_ack) else $error("acknowledge longer than one cycle");
	a_start: assert property (p_start) else $error("start bit missing");
endmodule : pdr_remote_io_props

// file: testbench/pdr_host_model.sv
// serial host on the far side of the rs485 link: sends and receives 8N1 bytes
// assumes tasks are called from the bench; the line idles high as a biased bus would
`timescale 1ns/1ns
module pdr_host_model import pdr_pkg::*; #(
	parameter int unsigned BIT_CYC = 16
) (
	input wire logic core_clk,
	output logic rs485_rx,
	input wire logic rs485_tx,
	input wire logic rs485_tx_oe
);
	// a single host with one address sits on this link, so no bus contention is modelled
	initial rs485_rx = 1'b1;
	// gap lets the host answer promptly or slowly; start low, data lsb first, stop high
	task automatic tx_byte(input logic [7:0] b, input int unsigned gap);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		repeat (gap) @(posedge core_clk);
		for (int i = 0; i < 10; i++) begin
			@(posedge core_clk);
			rs485_rx <= fr[i];
			repeat (BIT_CYC - 1) @(posedge core_clk);
		end
	endtask : tx_byte
	// sample mid-bit, starting from the first low seen while the driver is enabled
	task automatic rx_byte(output logic [7:0] b, output logic stop_ok);
		@(posedge core_clk iff (rs485_tx_oe === 1'b1 && rs485_tx === 1'b0));
		repeat (BIT_CYC / 2) @(posedge core_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge core_clk);
			b[i] = rs485_tx;
		end
		repeat (BIT_CYC) @(posedge core_clk);
		stop_ok = rs485_tx;
	endtask : rx_byte
endmodule : pdr_host_model

// file: testbench/pdr_remote_io_tb.sv
// self-checking bench for the pump drive remote-control block
// assumes short debounce, acknowledge and baud parameters so the run stays brief
`timescale 1ns/1ns
module pdr_remote_io_tb import pdr_pkg::*;;
	localparam int unsigned DEB = 4;
	localparam int unsigned ACK = 20;
	localparam int unsigned BAUD = 16;
	logic core_clk, rstn, avs_read, avs_write, avs_waitrequest, self_test_ok, error_present, warning_present;
	logic error_ack, speed_reached_output, fault_free_output, remote_prio_output, rs485_rx, rs485_tx, rs485_tx_oe;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, d;
	logic [15:0] speed_setpoint_input;
	logic [9:0] rotor_speed, speed_target, speed_analog_output;
	logic [7:0] b;
	logic ok;
	pdr_remote_in_type remote_in;
	pdr_drive_cmd_type drive_cmd;
	pdr_relay_type relays;
	int mismatches = 0;
	int checked = 0;
	int acks = 0;
	int n0;
	pdr_remote_io #(.DEB_CYC(DEB), .ACK_CYC(ACK), .BAUD_CYC(BAUD)) dut (.core_clk(core_clk), .rstn(rstn),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.remote_in(remote_in), .speed_setpoint_input(speed_setpoint_input), .self_test_ok(self_test_ok),
		.rotor_speed(rotor_speed), .error_present(error_present), .warning_present(warning_present),
		.drive_cmd(drive_cmd), .speed_target(speed_target), .error_ack(error_ack),
		.speed_reached_output(speed_reached_output), .fault_free_output(fault_free_output),
		.remote_prio_output(remote_prio_output), .speed_analog_output(speed_analog_output), .relays(relays),
		.rs485_rx(rs485_rx), .rs485_tx(rs485_tx), .rs485_tx_oe(rs485_tx_oe));
	pdr_host_model #(.BIT_CYC(BAUD)) host (.core_clk(core_clk), .rs485_rx(rs485_rx), .rs485_tx(rs485_tx),
		.rs485_tx_oe(rs485_tx_oe));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// count acknowledge pulses; the pulse stands one cycle only
	always @(posedge core_clk) if (error_ack === 1'b1) acks <= acks + 1;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// request held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	// debounce plus sync and output stages, with margin
	task automatic settle; repeat (DEB + 8) @(posedge core_clk); endtask : settle
	task automatic t_regs;
		bus(0, REG_MAP, 0); chk("map reset", 32'h124, d);
		bus(0, REG_SPEED, 0); chk("speed reset", {6'h0, SWITCH_RST, 6'h0, STANDBY_RST}, d);
		bus(0, 5'h1c, 0); chk("unmapped read", 32'h0, d);
		bus(1, REG_ADDR, 32'h7);
		bus(0, REG_ADDR, 0); chk("device address", 32'h7, d);
		$display("test registers done");
	endtask : t_regs
	task automatic t_remote;
		remote_in <= 8'h86;
		settle; chk("motor start", 6'h03, drive_cmd);
		chk("station ack", 1, acks);
		remote_in <= 8'h84;
		settle; chk("motor stop", 6'h02, drive_cmd);
		remote_in <= 8'hbd;
		settle; chk("all functions", 6'h3e, drive_cmd);
		chk("standby speed", STANDBY_RST, speed_target);
		self_test_ok <= 1'b0;
		remote_in <= 8'h86;
		settle; chk("no self test", 6'h02, drive_cmd);
		self_test_ok <= 1'b1;
		settle; chk("self test ok", 6'h03, drive_cmd);
		chk("nominal speed", SPEED_FULL, speed_target);
		$display("test remote inputs done");
	endtask : t_remote
	task automatic t_setpoint;
		logic [15:0] mv [4] = '{16'd5000, 16'd1999, 16'd2000, 16'd10000};
		logic [9:0] pm [4] = '{10'd500, 10'd1000, 10'd200, 10'd1000};
		for (int i = 0; i < 4; i++) begin
			speed_setpoint_input <= mv[i];
			repeat (6) @(posedge core_clk);
			chk("speed target", pm[i], speed_target);
		end
		$display("test setpoint done");
	endtask : t_setpoint
	task automatic t_status;
		logic [9:0] v [3] = '{10'd799, 10'd800, 10'd1000};
		for (int i = 0; i < 3; i++) begin
			rotor_speed <= v[i];
			repeat (3) @(posedge core_clk);
			chk("speed reached", v[i] >= SWITCH_RST, speed_reached_output);
			chk("relay one", v[i] >= SWITCH_RST, relays.relay1);
			chk("analog", v[i], speed_analog_output);
		end
		error_present <= 1'b1;
		warning_present <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk("fault free on error", 0, fault_free_output);
		chk("relays on error", 3'b101, relays);
		error_present <= 1'b0;
		warning_present <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk("relays clear", 3'b011, relays);
		$display("test status outputs done");
	endtask : t_status
	task automatic t_ack;
		n0 = acks;
		remote_in.err_ack <= 1'b1;
		repeat (ACK / 2) @(posedge core_clk);
		remote_in.err_ack <= 1'b0;
		repeat (ACK + DEB + 8) @(posedge core_clk);
		chk("short ack ignored", 0, acks - n0);
		remote_in.err_ack <= 1'b1;
		repeat (ACK + DEB + 10) @(posedge core_clk);
		remote_in.err_ack <= 1'b0;
		settle; chk("long ack", 1, acks - n0);
		$display("test acknowledge done");
	endtask : t_ack
	task automatic t_prio;
		remote_in <= 8'h04;
		bus(1, REG_CMD, 32'h10);
		settle; chk("software command", 6'h10, drive_cmd);
		chk("prio status off", 0, remote_prio_output);
		remote_in <= 8'h84;
		settle; chk("remote wins", 6'h02, drive_cmd);
		chk("prio status on", 1, remote_prio_output);
		$display("test priority done");
	endtask : t_prio
	task automatic t_serial;
		bus(1, REG_TXDATA, 32'ha5);
		host.rx_byte(b, ok); chk("tx byte", 8'ha5, b);
		chk("tx stop", 1, ok);
		host.tx_byte(8'h39, 24 * BAUD);
		host.tx_byte(8'h36, 0);
		host.tx_byte(8'h33, 0);
		host.tx_byte(8'h3c, 3 * BAUD);
		bus(0, REG_RXDATA, 0); chk("group frame", 32'h13c, d);
		bus(0, REG_RXDATA, 0); chk("valid cleared", 0, d[8]);
		host.tx_byte(8'h30, 24 * BAUD);
		host.tx_byte(8'h30, 0);
		host.tx_byte(8'h35, 0);
		host.tx_byte(8'h11, 0);
		bus(0, REG_RXDATA, 0); chk("foreign frame", 0, d[8]);
		$display("test serial done");
	endtask : t_serial
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	initial begin
		rstn = 1'b0;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		remote_in = '0;
		speed_setpoint_input = 16'h0;
		self_test_ok = 1'b1;
		rotor_speed = 10'h0;
		error_present = 1'b0;
		warning_present = 1'b0;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		t_regs;
		t_remote;
		t_setpoint;
		t_status;
		t_ack;
		t_prio;
		t_serial;
		tally_and_finish;
	end
	// the tests take under 5000 cycles
	initial begin
		repeat (40000) @(posedge core_clk);
		mismatches++;
		tally_and_finish;
	end
endmodule : pdr_remote_io_tb
bind pdr_remote_io pdr_remote_io_props u_props (.core_clk(core_clk), .rstn(rstn), .remote_in(remote_in),
	.rotor_speed(rotor_speed), .error_present(error_present), .warning_present(warning_present),
	.drive_cmd(drive_cmd), .error_ack(error_ack), .speed_reached_output(speed_reached_output),
	.fault_free_output(fault_free_output), .remote_prio_output(remote_prio_output),
	.speed_analog_output(speed_analog_output), .relays(relays), .rs485_tx(rs485_tx), .rs485_tx_oe(rs485_tx_oe));
